// file: pkg/mode_sel_cfg.svh
/*
 * Offsets, field positions and debug map windows of the operating mode block.
 * Assumes 16-bit register addresses and an 8-bit register data path.
 */
`ifndef MODE_SEL_CFG_SVH
`define MODE_SEL_CFG_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define OMC_OFFSET      16'h000B
`define ALT_OFFSET      16'h0030

// ----------------------------------------------------------------
// Field positions of the mode control register
// ----------------------------------------------------------------
`define OMC_SPEC_N_BIT  7
`define OMC_MODE_SELECT_B_BIT    6
`define OMC_MODE_SELECT_A_BIT    5
`define OMC_BUS_CLOCK_STRETCH_ENABLE_BIT    4
`define OMC_INTERNAL_BUS_VISIBILITY_BIT    3
`define OMC_WSD_BIT     2
`define OMC_EME_BIT     0

// ----------------------------------------------------------------
// Debug map windows
// ----------------------------------------------------------------
`define DBG_ROM_LO      16'hFF20
`define DBG_ROM_HI      16'hFFFF
`define DBG_REG_LO      16'hFF00
`define DBG_REG_HI      16'hFF06

`endif

// file: pkg/mode_sel_pkg.sv
/*
 * Types of the operating mode block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package mode_sel_pkg;

    // ----------------------------------------------------------------
    // Mode code {special_low, b, a}
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_SPC_SINGLE = 3'h0,
        MODE_SPC_NARROW = 3'h1,
        MODE_SPC_PERIPH = 3'h2,
        MODE_SPC_WIDE   = 3'h3,
        MODE_NRM_SINGLE = 3'h4,
        MODE_NRM_NARROW = 3'h5,
        MODE_NRM_RSVD   = 3'h6,
        MODE_NRM_WIDE   = 3'h7
    } mode_code_t;

    // ----------------------------------------------------------------
    // Narrow bus byte sequencer
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        NB_IDLE = 3'h1,
        NB_HIGH = 3'h2,
        NB_LOW  = 3'h4
    } narrow_state_t;

endpackage

// file: core/operating_mode_select.sv
/*
 * Operating mode selection, mode control register, map removal,
 * background debug enable/activate and external bus byte sequencing.
 * Assumes register port on core_clk, mode pins asynchronous, and a
 * CPU that requests external transfers with a one-cycle strobe.
 */
// Design decision made here: the plain strobed port.
// Function
// - Mode comes from pins held during reset
// - Pins captured at reset release into bits
// - Mode encoding per table, reserved forced peripheral
// - Single chip: no external bus, ports GPIO
// - Wide modes: 16-bit multiplexed bus ports A,B
// - Narrow: 8-bit data, high byte first
// - Second narrow byte uses incremented address
// - Peripheral mode: CPU inactive, external master
// - Peripheral mode entered or left only by reset
// - Normal modes protect bits; special modes wider
// - Special single chip leaves reset debug active
// - Other modes need debug enabled first
// - Activate by serial command or background instruction
// - Debug ROM and registers mapped when active
// - User top memory removed while debug active
// - Mode register resets per mode
// - Mode register unmapped in peripheral mode
// - Special bit writable in special, first ignored
// - Mode B/A write once normal, special after first
// - Runtime writes never pick peripheral or reserved
// - Ports A,B unmapped in expanded, peripheral
// - Port E unmapped peripheral, expanded with emulation
// - Clock stretch reads 1 in expanded modes
// - Single chip keeps port E mapped
`include "mode_sel_cfg.svh"
`timescale 1ns/10ps
`default_nettype none

module operating_mode_select (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        debug_serial_pin,
    input  wire logic        mode_select_b,
    input  wire logic        mode_select_a,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        debug_enable_cmd,
    input  wire logic        debug_activate_cmd,
    input  wire logic        background_instruction,
    input  wire logic        debug_exit,
    input  wire logic        ext_req,
    input  wire logic        ext_word,
    input  wire logic [15:0] ext_addr,
    input  wire logic [15:0] ext_wdata,
    input  wire logic [15:0] cpu_addr,
    output logic             ext_busy,
    output logic      [15:0] bus_addr,
    output logic      [15:0] bus_data,
    output logic             bus_cycle,
    output logic             bus_present,
    output logic             bus_wide,
    output logic             cpu_run,
    output logic             background_debug_enabled,
    output logic             background_debug_active,
    output logic             debug_rom_sel,
    output logic             debug_reg_sel,
    output logic             user_top_hidden,
    output logic             port_ab_mapped,
    output logic             port_e_mapped,
    output logic             mode_reg_mapped
);

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] pin_meta_q;
    logic [2:0] pin_sync_q;
    logic       in_reset_q;

    always_ff @(posedge core_clk) begin
        pin_meta_q <= {debug_serial_pin, mode_select_b, mode_select_a};
        pin_sync_q <= pin_meta_q;
    end

    // ----------------------------------------------------------------
    // Mode register state
    // ----------------------------------------------------------------
    logic [2:0] mode_q;
    logic       bus_clock_stretch_enable_q;
    logic       internal_bus_visibility_q;
    logic       wsd_q;
    logic       eme_q;
    logic       first_wr_q;
    logic       mode_wr_once_q;
    logic       bus_clock_stretch_enable_wr_once_q;
    logic       internal_bus_visibility_wr_once_q;
    logic       eme_wr_once_q;

    wire logic [2:0] pin_mode    = (pin_sync_q == 3'h6) ? 3'h2 : pin_sync_q;
    wire logic       special     = ~mode_q[2];
    wire logic       periph      = (mode_q == 3'h2);
    wire logic       single_chip = (mode_q[1:0] == 2'h0);
    wire logic       expanded    = ~single_chip & ~periph;
    wire logic       wide        = (mode_q[1:0] == 2'h3) | periph;

    wire logic       omc_hit = (reg_addr == `OMC_OFFSET) & ~periph;
    wire logic       omc_wr  = reg_wr & omc_hit & ~in_reset_q;
    wire logic       alt_hit = (reg_addr == `ALT_OFFSET);

    // Special bit: special modes only, not the first write
    wire logic       spec_ok = special & ~first_wr_q;
    wire logic       new_s   = spec_ok ? reg_wdata[`OMC_SPEC_N_BIT] : mode_q[2];
    // Mode B/A: once in normal, special after first write
    wire logic       ba_ok   = special ? ~first_wr_q : ~mode_wr_once_q;
    wire logic [1:0] new_ba  = ba_ok ? reg_wdata[`OMC_MODE_SELECT_B_BIT:`OMC_MODE_SELECT_A_BIT] : mode_q[1:0];
    wire logic [2:0] new_mode = {new_s, new_ba};
    // Peripheral and reserved codes kept out; periph can't leave
    wire logic       mode_ok = ~periph & (new_mode != 3'h2) & (new_mode != 3'h6);

    // Normal: write once, wsd anytime; special: anytime (stretch), after first (internal_bus_visibility, eme), never (wsd)
    wire logic       bus_clock_stretch_enable_ok = special | ~bus_clock_stretch_enable_wr_once_q;
    wire logic       internal_bus_visibility_ok = special ? ~first_wr_q : ~internal_bus_visibility_wr_once_q;
    wire logic       eme_ok  = special ? ~first_wr_q : ~eme_wr_once_q;
    wire logic       wsd_ok  = ~special;

    always_ff @(posedge core_clk) begin
        in_reset_q <= srst;
        if (srst) begin
            mode_q         <= 3'h2;
            bus_clock_stretch_enable_q         <= 1'b1;
            internal_bus_visibility_q         <= 1'b0;
            wsd_q          <= 1'b0;
            eme_q          <= 1'b0;
            first_wr_q     <= 1'b1;
            mode_wr_once_q <= 1'b0;
            bus_clock_stretch_enable_wr_once_q <= 1'b0;
            internal_bus_visibility_wr_once_q <= 1'b0;
            eme_wr_once_q  <= 1'b0;
        end else if (in_reset_q) begin
            // Capture at reset release, per-mode reset values
            mode_q <= pin_mode;
            bus_clock_stretch_enable_q <= 1'b1;
            internal_bus_visibility_q <= ~pin_mode[2];
            eme_q  <= ~pin_mode[2];
            wsd_q  <= 1'b0;
        end else if (omc_wr) begin
            first_wr_q     <= 1'b0;
            mode_wr_once_q <= 1'b1;
            bus_clock_stretch_enable_wr_once_q <= 1'b1;
            internal_bus_visibility_wr_once_q <= 1'b1;
            eme_wr_once_q  <= 1'b1;
            if (mode_ok) begin
                mode_q <= new_mode;
            end
            if (bus_clock_stretch_enable_ok) begin
                bus_clock_stretch_enable_q <= reg_wdata[`OMC_BUS_CLOCK_STRETCH_ENABLE_BIT];
            end
            if (internal_bus_visibility_ok) begin
                internal_bus_visibility_q <= reg_wdata[`OMC_INTERNAL_BUS_VISIBILITY_BIT];
            end
            if (eme_ok) begin
                eme_q <= reg_wdata[`OMC_EME_BIT];
            end
            if (wsd_ok) begin
                wsd_q <= reg_wdata[`OMC_WSD_BIT];
            end
        end
    end

    // ----------------------------------------------------------------
    // Background debug
    // ----------------------------------------------------------------
    logic dbg_en_q;
    logic dbg_act_q;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            dbg_en_q  <= 1'b0;
            dbg_act_q <= 1'b0;
        end else if (in_reset_q) begin
            dbg_en_q  <= (pin_mode == 3'h0);
            dbg_act_q <= (pin_mode == 3'h0);
        end else begin
            if (debug_enable_cmd) begin
                dbg_en_q <= 1'b1;
            end
            if (dbg_en_q & (debug_activate_cmd | background_instruction)) begin
                dbg_act_q <= 1'b1;
            end else if (debug_exit) begin
                dbg_act_q <= 1'b0;
            end
        end
    end

    assign background_debug_enabled = dbg_en_q;
    assign background_debug_active  = dbg_act_q;
    assign debug_rom_sel   = dbg_act_q & (cpu_addr >= `DBG_ROM_LO);
    assign debug_reg_sel   = dbg_act_q & (cpu_addr >= `DBG_REG_LO) & (cpu_addr <= `DBG_REG_HI);
    assign user_top_hidden = dbg_act_q & (cpu_addr >= `DBG_REG_LO);

    // ----------------------------------------------------------------
    // Map control and mode outputs
    // ----------------------------------------------------------------
    assign port_ab_mapped  = single_chip;
    assign port_e_mapped   = single_chip | (expanded & ~eme_q);
    assign mode_reg_mapped = ~periph;
    assign bus_present     = ~single_chip & ~in_reset_q;
    assign bus_wide        = wide;
    assign cpu_run         = ~periph & ~in_reset_q & ~srst;

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    wire logic       bus_clock_stretch_enable_rd = bus_clock_stretch_enable_q | expanded;
    wire logic [7:0] omc_val = {mode_q, bus_clock_stretch_enable_rd, internal_bus_visibility_q, wsd_q, 1'b0, eme_q};
    wire logic [7:0] alt_val = {5'h00, dbg_act_q, dbg_en_q, periph};
    wire logic [7:0] rd_mux  = omc_hit ? omc_val : (alt_hit ? alt_val : 8'h00);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // External bus sequencer
    // ----------------------------------------------------------------
    mode_sel_pkg::narrow_state_t nb_q;
    mode_sel_pkg::narrow_state_t nb_d;
    logic [15:0] held_addr_q;
    logic [15:0] held_data_q;

    wire logic start    = ext_req & bus_present & (nb_q == mode_sel_pkg::NB_IDLE);
    wire logic two_byte = ext_word & ~wide;

    always_comb begin
        case (nb_q)
            mode_sel_pkg::NB_IDLE: nb_d = (start & two_byte) ? mode_sel_pkg::NB_HIGH : mode_sel_pkg::NB_IDLE;
            mode_sel_pkg::NB_HIGH: nb_d = mode_sel_pkg::NB_LOW;
            mode_sel_pkg::NB_LOW:  nb_d = mode_sel_pkg::NB_IDLE;
            default:               nb_d = mode_sel_pkg::NB_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            nb_q        <= mode_sel_pkg::NB_IDLE;
            held_addr_q <= 16'h0000;
            held_data_q <= 16'h0000;
            bus_addr    <= 16'h0000;
            bus_data    <= 16'h0000;
            bus_cycle   <= 1'b0;
        end else begin
            nb_q      <= nb_d;
            bus_cycle <= 1'b0;
            if (start) begin
                held_addr_q <= ext_addr;
                held_data_q <= ext_wdata;
                if (~two_byte) begin
                    bus_addr  <= ext_addr;
                    bus_data  <= wide ? ext_wdata : {8'h00, ext_wdata[7:0]};
                    bus_cycle <= 1'b1;
                end
            end else if (nb_q == mode_sel_pkg::NB_HIGH) begin
                bus_addr  <= held_addr_q;
                bus_data  <= {8'h00, held_data_q[15:8]};
                bus_cycle <= 1'b1;
            end else if (nb_q == mode_sel_pkg::NB_LOW) begin
                bus_addr  <= held_addr_q + 16'h0001;
                bus_data  <= {8'h00, held_data_q[7:0]};
                bus_cycle <= 1'b1;
            end
        end
    end

    assign ext_busy = (nb_q != mode_sel_pkg::NB_IDLE);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_NO_PERIPH_WRITE: assert property (@(posedge core_clk) disable iff (srst)
        omc_wr |=> (mode_q != 3'h2 || $past(mode_q) == 3'h2) && mode_q != 3'h6)
        else $error("Runtime write selected peripheral or reserved mode");
    AST_PERIPH_STAYS: assert property (@(posedge core_clk) disable iff (srst | in_reset_q)
        (periph && !in_reset_q) |=> periph)
        else $error("Peripheral mode left without reset");
    AST_NARROW_SEQ: assert property (@(posedge core_clk) disable iff (srst)
        (start & two_byte) |-> ##2 (bus_cycle && bus_addr == $past(ext_addr, 2)) ##1
        (bus_cycle && bus_addr == $past(ext_addr, 3) + 16'h0001))
        else $error("Narrow transfer byte addresses wrong");
    AST_CAPTURE: assert property (@(posedge core_clk) disable iff (srst)
        (in_reset_q && !srst) |=> mode_q == $past(pin_mode))
        else $error("Mode not captured at reset release");
    AST_SSC_DEBUG: assert property (@(posedge core_clk) disable iff (srst)
        (in_reset_q && !srst && pin_mode == 3'h0) |=> dbg_act_q)
        else $error("Debug not active after special single chip reset");
    AST_DEBUG_GATED: assert property (@(posedge core_clk) disable iff (srst)
        (!dbg_act_q && !dbg_en_q && !in_reset_q) |=> !dbg_act_q)
        else $error("Debug active without enable");
    AST_PORTAB_MAP: assert property (@(posedge core_clk) disable iff (srst)
        (mode_q[1:0] != 2'h0) |-> !port_ab_mapped)
        else $error("Port A/B mapped outside single chip");
    AST_STRETCH_READ: assert property (@(posedge core_clk) disable iff (srst)
        (reg_rd && omc_hit && expanded) |=> reg_rdata[`OMC_BUS_CLOCK_STRETCH_ENABLE_BIT])
        else $error("Clock stretch read as zero in expanded mode");
    AST_NO_BUS_SINGLE: assert property (@(posedge core_clk) disable iff (srst)
        single_chip |-> !bus_present && !bus_cycle)
        else $error("External bus in single chip mode");

    // ----------------------------------------------------------------
    // Map, protection and transfer checks
    // ----------------------------------------------------------------
    AST_DBG_REG_MAP: assert property (@(posedge core_clk) disable iff (srst)
        (dbg_act_q && cpu_addr >= `DBG_REG_LO && cpu_addr <= `DBG_REG_HI) |-> debug_reg_sel && !debug_rom_sel)
        else $error("Debug register window not selected");
    AST_TOP_HIDDEN: assert property (@(posedge core_clk) disable iff (srst)
        (dbg_act_q && cpu_addr[15:8] == 8'hFF) |-> user_top_hidden)
        else $error("User top memory visible in debug");
    AST_MODE_REG_GONE: assert property (@(posedge core_clk) disable iff (srst)
        (periph && reg_rd && reg_addr == `OMC_OFFSET) |=> reg_rdata == 8'h00)
        else $error("Mode register read in peripheral mode");
    AST_PERIPH_WR_IGNORED: assert property (@(posedge core_clk) disable iff (srst)
        (periph && !in_reset_q && reg_wr) |=> $stable({bus_clock_stretch_enable_q, internal_bus_visibility_q, wsd_q, eme_q}) && periph)
        else $error("Mode register written in peripheral mode");
    AST_SPEC_FIRST: assert property (@(posedge core_clk) disable iff (srst)
        (omc_wr && first_wr_q) |=> mode_q[2] == $past(mode_q[2]))
        else $error("First write changed the special bit");
    AST_SPEC_WRITE: assert property (@(posedge core_clk) disable iff (srst)
        (omc_wr && spec_ok && mode_ok) |=> mode_q[2] == $past(reg_wdata[`OMC_SPEC_N_BIT]))
        else $error("Special bit write lost");
    AST_NORMAL_ONCE: assert property (@(posedge core_clk) disable iff (srst)
        (omc_wr && !special && mode_wr_once_q) |=> mode_q == $past(mode_q))
        else $error("Mode bits written twice in normal mode");
    AST_PORT_E_DATA_SINGLE: assert property (@(posedge core_clk) disable iff (srst)
        single_chip |-> port_e_mapped)
        else $error("Port E unmapped in single chip mode");
    AST_PORT_E_DATA_UNMAP: assert property (@(posedge core_clk) disable iff (srst)
        (periph || (expanded && eme_q)) |-> !port_e_mapped)
        else $error("Port E mapped where removed");
    AST_RESET_VALUES: assert property (@(posedge core_clk) disable iff (srst)
        (in_reset_q && !srst) |=> bus_clock_stretch_enable_q && !wsd_q && (internal_bus_visibility_q == special) && (eme_q == special))
        else $error("Mode register reset values wrong");
    AST_WSD_SPECIAL: assert property (@(posedge core_clk) disable iff (srst)
        (omc_wr && special) |=> $stable(wsd_q))
        else $error("Wait shutdown bit written in special mode");
    AST_CPU_HALT: assert property (@(posedge core_clk) disable iff (srst)
        periph |-> !cpu_run)
        else $error("CPU running in peripheral mode");
    AST_NARROW_BUSY: assert property (@(posedge core_clk) disable iff (srst)
        (start & two_byte) |=> ext_busy ##1 ext_busy ##1 !ext_busy)
        else $error("Narrow transfer busy window wrong");
    AST_NARROW_HIGH: assert property (@(posedge core_clk) disable iff (srst)
        (start & two_byte) |-> ##2 bus_data == {8'h00, $past(ext_wdata[15:8], 2)})
        else $error("High byte not sent first");
    AST_WIDE_BUS: assert property (@(posedge core_clk) disable iff (srst)
        (start & wide) |=> bus_cycle && bus_data == $past(ext_wdata))
        else $error("Wide transfer data wrong");
    AST_NO_RESERVED: assert property (@(posedge core_clk) disable iff (srst)
        mode_q != 3'h6)
        else $error("Reserved mode code held");
    AST_ACT_SOURCE: assert property (@(posedge core_clk) disable iff (srst)
        $rose(dbg_act_q) |-> $past(debug_activate_cmd | background_instruction | in_reset_q))
        else $error("Debug activated without a command");

    COV_NARROW: cover property (@(posedge core_clk) disable iff (srst) start & two_byte);
    COV_WIDE: cover property (@(posedge core_clk) disable iff (srst) start & wide & ext_word);
    COV_DBG_ACT: cover property (@(posedge core_clk) disable iff (srst) dbg_en_q & background_instruction);
    COV_MODE_SW: cover property (@(posedge core_clk) disable iff (srst) omc_wr & mode_ok & ba_ok);

endmodule

`default_nettype wire

// file: verification/ext_side_model.sv
/* Far side of the block: strap driver and external bus observer.
   Assumes the straps only matter while srst is high. */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Straps and bus cycle count
// ----------------------------------------
module ext_side_model (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic [2:0]  strap,
    input  wire logic        bus_cycle,
    output logic      [2:0]  pins,
    output logic      [15:0] n_cycles
);
    logic [2:0] churn_q;
    // Held through reset, churning once released
    assign pins = srst ? strap : churn_q;
    always_ff @(posedge core_clk) begin
        churn_q <= srst ? ~strap : ~churn_q;
        n_cycles <= srst ? 16'h0000 : n_cycles + {15'h0000, bus_cycle};
    end
endmodule
`default_nettype wire

// file: verification/operating_mode_select_test.sv
/* Self-checking bench of the operating mode block.
   Assumes the package, the header and the far side model. */
`include "mode_sel_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module operating_mode_select_test;
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    logic [2:0]  strap = 3'h4;
    logic [2:0]  pins;
    logic [15:0] n_cycles;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic [3:0]  dbg = 4'h0;
    logic        ext_req = 1'b0;
    logic        ext_word = 1'b0;
    logic [15:0] ext_addr = 16'h0000;
    logic [15:0] ext_wdata = 16'h0000;
    logic [15:0] cpu_addr = 16'h0000;
    logic [15:0] bus_addr, bus_data;
    logic ext_busy, bus_cycle, bus_present, bus_wide, cpu_run;
    logic background_debug_enabled, background_debug_active;
    logic debug_rom_sel, debug_reg_sel, user_top_hidden;
    logic port_ab_mapped, port_e_mapped, mode_reg_mapped;
    logic [31:0] bus_q[$];
    logic [7:0]  rd_q[$];
    logic        rd_wait = 1'b0;
    logic [15:0] dmask = 16'hFFFF;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cycles = 0;

    operating_mode_select i_dut (.core_clk(core_clk), .srst(srst), .debug_serial_pin(pins[2]),
        .mode_select_b(pins[1]), .mode_select_a(pins[0]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .debug_enable_cmd(dbg[0]),
        .debug_activate_cmd(dbg[1]), .background_instruction(dbg[2]), .debug_exit(dbg[3]),
        .ext_req(ext_req), .ext_word(ext_word), .ext_addr(ext_addr), .ext_wdata(ext_wdata),
        .cpu_addr(cpu_addr), .ext_busy(ext_busy), .bus_addr(bus_addr), .bus_data(bus_data),
        .bus_cycle(bus_cycle), .bus_present(bus_present), .bus_wide(bus_wide), .cpu_run(cpu_run),
        .background_debug_enabled(background_debug_enabled), .background_debug_active(background_debug_active),
        .debug_rom_sel(debug_rom_sel), .debug_reg_sel(debug_reg_sel), .user_top_hidden(user_top_hidden),
        .port_ab_mapped(port_ab_mapped), .port_e_mapped(port_e_mapped), .mode_reg_mapped(mode_reg_mapped));
    ext_side_model i_far (.core_clk(core_clk), .srst(srst), .strap(strap), .bus_cycle(bus_cycle), .pins(pins),
        .n_cycles(n_cycles));

    always #12.5 core_clk = ~core_clk;

    // ----------------------------------------
    // Checking
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        if (n_errors == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            finish_test();
        end
    end

    always @(negedge core_clk) begin
        if (rd_wait) check(reg_rdata, rd_q.pop_front());
        rd_wait = reg_rd;
        if (bus_cycle && bus_q.size() == 0) check(1, 0);
        else if (bus_cycle) check({bus_addr, bus_data & dmask}, bus_q.pop_front());
    end

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    task automatic restart(input logic [2:0] code);
        @(posedge core_clk);
        strap <= code;
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge core_clk);
        reg_rd <= 1'b0;
    endtask

    task automatic pulse(input int i);
        @(posedge core_clk);
        dbg <= 4'h1 << i;
        @(posedge core_clk);
        dbg <= 4'h0;
        @(negedge core_clk);
    endtask

    // Kind 0 expects no cycle, 1 one wide cycle, 2 two byte cycles
    task automatic xfer(input int kind);
        logic [15:0] a;
        logic [15:0] d;
        a = 16'($urandom);
        d = 16'($urandom);
        @(posedge core_clk);
        ext_req <= 1'b1;
        ext_word <= 1'b1;
        ext_addr <= a;
        ext_wdata <= d;
        if (kind == 1) bus_q.push_back({a, d});
        if (kind == 2) bus_q.push_back({a, 8'h00, d[15:8]});
        if (kind == 2) bus_q.push_back({a + 16'h0001, 8'h00, d[7:0]});
        @(posedge core_clk);
        // Narrow: request held into the busy cycle must be refused
        if (kind == 2) begin
            @(negedge core_clk);
            check(ext_busy, 1'b1);
            @(posedge core_clk);
        end
        ext_req <= 1'b0;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        check(ext_busy, 1'b0);
    endtask

    initial begin
        void'($urandom(32'h5387));
        for (int c = 0; c < 8; c++) begin
            logic [2:0] m;
            logic p;
            logic s;
            int k;
            m = (c == 6) ? 3'h2 : 3'(c);
            p = (m == 3'h2);
            s = (m[1:0] == 2'h0);
            k = (p || !m[0]) ? 0 : (m[1] ? 1 : 2);
            restart(3'(c));
            check(cpu_run, !p);
            check(mode_reg_mapped, !p);
            check(port_ab_mapped, s);
            check(port_e_mapped, s || (!p && m[2]));
            check(background_debug_active, m == 3'h0);
            if (!p) check(bus_present, !s);
            if (!p && !s) check(bus_wide, m[1]);
            rd(`OMC_OFFSET, p ? 8'h00 : {m, 1'b1, ~m[2], 2'b00, ~m[2]});
            rd(`ALT_OFFSET, {5'h00, m == 3'h0, m == 3'h0, p});
            if (p) wr(`OMC_OFFSET, 8'h79);
            if (p) rd(`ALT_OFFSET, 8'h01);
            dmask = m[1] ? 16'hFFFF : 16'h00FF;
            if (!p) xfer(k);
            check(n_cycles, k);
        end
        restart(3'h0);
        wr(`OMC_OFFSET, 8'h79);
        rd(`OMC_OFFSET, 8'h19);
        wr(`OMC_OFFSET, 8'h59);
        rd(`OMC_OFFSET, 8'h19);
        wr(`OMC_OFFSET, 8'h79);
        rd(`OMC_OFFSET, 8'h79);
        wr(`OMC_OFFSET, 8'hF9);
        rd(`OMC_OFFSET, 8'hF9);
        wr(`OMC_OFFSET, 8'hD9);
        rd(`OMC_OFFSET, 8'hF9);
        @(negedge core_clk);
        check(port_e_mapped, 1'b0);
        restart(3'h4);
        wr(`OMC_OFFSET, 8'hE4);
        rd(`OMC_OFFSET, 8'hF4);
        wr(`OMC_OFFSET, 8'hA0);
        rd(`OMC_OFFSET, 8'hF0);
        rd(16'h0002, 8'h00);
        wr(`ALT_OFFSET, 8'hFF);
        pulse(1);
        check(background_debug_active, 1'b0);
        pulse(0);
        check({background_debug_enabled, background_debug_active}, 2'b10);
        pulse(2);
        check(background_debug_active, 1'b1);
        rd(`ALT_OFFSET, 8'h06);
        for (int i = 0; i < 16; i++) begin
            logic [15:0] a;
            a = 16'hFEF0 + 16'($urandom % 272);
            if (i < 4) a = (i == 0) ? 16'hFF1F : (i == 1) ? 16'hFF20 : (i == 2) ? 16'hFF06 : 16'hFF07;
            @(posedge core_clk);
            cpu_addr <= a;
            @(negedge core_clk);
            check(debug_rom_sel, a >= `DBG_ROM_LO);
            check(debug_reg_sel, a >= `DBG_REG_LO && a <= `DBG_REG_HI);
            check(user_top_hidden, a >= 16'hFF00);
        end
        pulse(3);
        check(background_debug_active, 1'b0);
        pulse(1);
        check(background_debug_active, 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
